// ---- hw/pbr_long_timer.sv ----
// module: one-shot down counter timing the long bus reset
`timescale 1ns/1ps
`default_nettype none
module pbr_long_timer #(
   parameter int CYCLES = 4150
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic start,
   output logic done
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam int LEAD = 3; // done leads: the caller reacts late

   // ==========================================================
   // state
   typedef struct packed {
      logic [CW-1:0] count; // cycles left to run
      logic done; // one-cycle end pulse
   } pbr_timer_t;

   pbr_timer_t s_r;
   pbr_timer_t s_nxt;

   if (CYCLES < LEAD) begin : gBadCycles
      $error("pbr_long_timer: CYCLES must be at least 3");
   end

   // load on start, count down, pulse done at LEAD
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (start) begin
         s_nxt.count = CW'(CYCLES);
      end else if (s_r.count != '0) begin
         s_nxt.count = s_r.count - CW'(1);
         s_nxt.done = (s_r.count == CW'(LEAD));
      end
   end

   // register with asynchronous clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign done = s_r.done;
endmodule : pbr_long_timer
`default_nettype wire

// ---- hw/pbr_phy_regs.sv ----
// module: phy base register file behind an ahb-lite slave
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pbr_phy_regs #(
   parameter int LONG_RESET_CYCLES = pbr_pkg::PBR_LONG_RESET_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // ahb-lite register slave
   input wire pbr_pkg::pbr_ahb_in_t ahbIn,
   output pbr_pkg::pbr_ahb_out_t ahbOut,
   // cable power pin, asynchronous
   input wire logic cablePowerStatus,
   // phy core events and controls
   input wire pbr_pkg::pbr_phy_in_t phyIn,
   output pbr_pkg::pbr_phy_out_t phyOut
);
   import pbr_pkg::*;

   // ==========================================================
   // elaboration checks
   // the timer raises done early and needs three counts
   if (LONG_RESET_CYCLES < 3) begin : gBadLongReset
      $error("pbr_phy_regs: LONG_RESET_CYCLES must be at least 3");
   end

   // ==========================================================
   // state of the block
   typedef struct packed {
      pbr_state_t state; // long reset sequencer
      logic [5:0] nodeAddress; // address from self-id
      logic root; // this node is root
      logic rootHoldoff; // writable, kept over bus reset
      logic initLongReset; // writable request for long reset
      logic [5:0] gapCount; // arbitration gap value
      logic gapStale; // one bus reset since last gap update
      logic [2:0] pageSelect; // page mapped onto 8h..Fh
      logic [3:0] portSelect; // port for paged port registers
      logic wrPend; // write data phase pending
      logic [3:0] wrIdx; // register index of that write
      logic timerStart; // one-cycle load of the timer
      pbr_ahb_out_t ahb; // registered bus answer
      pbr_phy_out_t phy; // registered pulses and levels to the phy core
   } pbr_core_t;

   localparam pbr_core_t CORE_RST = '{
      state: PBR_ST_IDLE,
      nodeAddress: 6'h00,
      root: 1'b0,
      rootHoldoff: 1'b0,
      initLongReset: 1'b0,
      gapCount: PBR_GAP_RESET,
      gapStale: 1'b0,
      pageSelect: 3'h0,
      portSelect: 4'h0,
      wrPend: 1'b0,
      wrIdx: 4'h0,
      timerStart: 1'b0,
      ahb: '{hreadyout: 1'b1, hresp: PBR_HRESP_OKAY, hrdata: 32'h0},
      phy: '{gapCount: PBR_GAP_RESET, default: '0}
   };

   pbr_core_t s_r; // current state
   pbr_core_t s_nxt; // next state
   logic rstSync_n; // reset, released through two flops
   logic cpsSync; // synchronised cable power level
   logic timerDone; // long reset has run its length

   // ==========================================================
   // functions
   // pack the register 0 image from the state
   // cable power comes from the synchroniser
   function automatic logic [7:0] nodeImage(input pbr_core_t c,
                                            input logic cable_power_status);
      pbr_reg_node_t r;
      r.nodeAddress = c.nodeAddress;
      r.root = c.root;
      r.cablePowerStatus = cable_power_status;
      return r;
   endfunction : nodeImage

   // word index of a byte address inside the map
   function automatic logic [3:0] addrIndex(input logic [31:0] a);
      return a[PBR_IDX_LSB +: PBR_IDX_W];
   endfunction : addrIndex

   // address falls inside the sixteen word map
   // else higher addresses would alias it
   function automatic logic addrMapped(input logic [31:0] a);
      return a[31:PBR_MAP_TOP] == '0;
   endfunction : addrMapped

   // read value of one register
   function automatic logic [7:0] regRead(input pbr_core_t c,
                                          input logic [3:0] idx,
                                          input logic cable_power_status);
      pbr_reg_gap_t g;
      pbr_reg_page_t p;
      logic [7:0] v;

      g.rootHoldoff = c.rootHoldoff;
      g.initiateLongReset = c.initLongReset;
      g.gapCount = c.gapCount;
      p.pageSelect = c.pageSelect;
      p.reserved = 1'b0;
      p.portSelect = c.portSelect;

      // anything not decoded reads zero
      v = 8'h00;
      if (idx[PBR_PAGED_BIT]) begin
         // paged window: reserved pages read zero, other pages hold
         // no fields in this block and read zero as well
         v = 8'h00;
      end else begin
         // base layout is the same on every page
         unique case (idx)
            PBR_IDX_NODE: v = nodeImage(c, cable_power_status);
            PBR_IDX_RESET_GAP: v = g;
            PBR_IDX_PORT_CAP: v = PBR_PORT_CAP_VAL;
            PBR_IDX_SPEED_CAP: v = PBR_SPEED_CAP_VAL;
            PBR_IDX_LINK_PWR: v = 8'h00; // fields outside this block
            PBR_IDX_EVENT: v = 8'h00; // fields outside this block
            PBR_IDX_RSVD: v = 8'h00;
            PBR_IDX_PAGE: v = p;
            default: v = 8'h00;
         endcase
      end
      return v;
   endfunction : regRead

   // ==========================================================
   // reset release and pin synchroniser
   // reset asserts at once, leaves on the clock
   pbr_sync #(.WIDTH(1)) uRstSync (
      .clk(sys_clk),
      .rst_n(rst_n),
      .d(1'b1),
      .q(rstSync_n)
   );

   // cable power pin sampled through two flops
   // a read lags the pin by two cycles
   pbr_sync #(.WIDTH(1)) uCpsSync (
      .clk(sys_clk),
      .rst_n(rstSync_n),
      .d(cablePowerStatus),
      .q(cpsSync)
   );

   // ==========================================================
   // long bus reset timer
   // done comes early since the sequencer
   // drops the drive one cycle after it
   pbr_long_timer #(.CYCLES(LONG_RESET_CYCLES)) uLongTimer (
      .clk(sys_clk),
      .rst_n(rstSync_n),
      .start(s_r.timerStart),
      .done(timerDone)
   );

   // ==========================================================
   // next state
   // precedence: write, packet, bus reset,
   // root, self-id, then the bus answer
   always_comb begin
      pbr_reg_gap_t wg;
      pbr_reg_page_t wp;
      logic gapTouch;
      logic [3:0] aIdx;

      wg = '0;
      wp = '0;
      gapTouch = 1'b0;
      aIdx = addrIndex(ahbIn.haddr);

      // hold all fields, pulses fall to zero
      s_nxt = s_r;
      s_nxt.timerStart = 1'b0;
      s_nxt.phy.statusXferReq = 1'b0;

      // data phase of a write: only writable fields change
      if (s_r.wrPend) begin
         unique case (s_r.wrIdx)
            PBR_IDX_RESET_GAP: begin
               wg = pbr_reg_gap_t'(ahbIn.hwdata[7:0]);
               s_nxt.rootHoldoff = wg.rootHoldoff;
               s_nxt.initLongReset = wg.initiateLongReset;
               s_nxt.gapCount = wg.gapCount;
               gapTouch = 1'b1;
            end
            PBR_IDX_PAGE: begin
               wp = pbr_reg_page_t'(ahbIn.hwdata[7:0]);
               s_nxt.pageSelect = wp.pageSelect;
               s_nxt.portSelect = wp.portSelect;
            end
            default: begin
               // read-only, reserved or paged: no effect
               s_nxt.wrIdx = s_r.wrIdx;
            end
         endcase
      end

      // gap count carried by a configuration packet either way
      if (phyIn.phyConfigRx || phyIn.phyConfigTx) begin
         s_nxt.gapCount = phyIn.phyConfigGap;
         gapTouch = 1'b1;
      end

      // any update restarts the count of bare bus resets
      // a same-cycle write or packet counts
      if (gapTouch) begin
         s_nxt.gapStale = 1'b0;
      end

      // bus reset: invalidate address, drop root and request
      // clears a request written this cycle
      if (phyIn.busReset) begin
         s_nxt.nodeAddress = s_r.nodeAddress;
         s_nxt.phy.nodeAddressValid = 1'b0;
         s_nxt.root = 1'b0;
         s_nxt.initLongReset = 1'b0;
         if (!gapTouch) begin
            // second bare reset in a row restores the default
            if (s_r.gapStale) begin
               s_nxt.gapCount = PBR_GAP_RESET;
            end
            s_nxt.gapStale = 1'b1;
         end
      end

      // tree identification chose this node; set beats clear
      if (phyIn.becameRoot) begin
         s_nxt.root = 1'b1;
      end

      // self-id done: latch address and send register 0 status
      // the image shows this cycle's root flag
      if (phyIn.selfIdDone) begin
         s_nxt.nodeAddress = phyIn.selfIdAddress;
         s_nxt.phy.nodeAddressValid = 1'b1;
         s_nxt.phy.statusXferReq = 1'b1;
         s_nxt.phy.statusXferData = nodeImage(s_nxt, cpsSync);
      end

      // long bus reset sequencer
      // waits out traffic, then drives
      unique case (s_r.state)
         PBR_ST_IDLE: begin
            // software asked for a long reset
            if (s_r.initLongReset) begin
               s_nxt.state = PBR_ST_WAIT;
            end
         end
         PBR_ST_WAIT: begin
            if (!s_r.initLongReset) begin
               // request withdrawn or cleared by a bus reset
               s_nxt.state = PBR_ST_IDLE;
            end else if (!phyIn.linkBusy) begin
               // traffic has finished, start driving the reset
               s_nxt.state = PBR_ST_DRIVE;
               s_nxt.timerStart = 1'b1;
               s_nxt.phy.longResetActive = 1'b1;
               s_nxt.initLongReset = 1'b0;
            end
         end
         PBR_ST_DRIVE: begin
            // hold the reset for its full length
            if (timerDone) begin
               s_nxt.state = PBR_ST_IDLE;
               s_nxt.phy.longResetActive = 1'b0;
            end
         end
         default: begin
            // unused code: recover quietly
            s_nxt.state = PBR_ST_IDLE;
            s_nxt.phy.longResetActive = 1'b0;
         end
      endcase

      // ahb-lite address phase: zero wait state, always OKAY
      // no transfer is ever stretched
      s_nxt.wrPend = 1'b0;
      s_nxt.ahb.hreadyout = 1'b1;
      s_nxt.ahb.hresp = PBR_HRESP_OKAY;
      if (ahbIn.hsel && ahbIn.htrans[PBR_HTRANS_ACTIVE] && ahbIn.hready)
      begin
         if (ahbIn.hwrite) begin
            // unmapped or narrow writes are dropped
            s_nxt.wrPend = addrMapped(ahbIn.haddr) &&
                           (ahbIn.hsize == PBR_HSIZE_WORD);
            s_nxt.wrIdx = aIdx;
         end else if (addrMapped(ahbIn.haddr)) begin
            // read sees the state after this cycle's updates
            s_nxt.ahb.hrdata = {24'h0, regRead(s_nxt, aIdx, cpsSync)};
         end else begin
            // outside the map reads zero
            s_nxt.ahb.hrdata = 32'h0;
         end
      end

      // mirror the steering fields to the phy core
      // the core sees a write after its data phase
      s_nxt.phy.rootHoldoff = s_nxt.rootHoldoff;
      s_nxt.phy.gapCount = s_nxt.gapCount;
      s_nxt.phy.pageSelect = s_nxt.pageSelect;
      s_nxt.phy.portSelect = s_nxt.portSelect;
   end

   // ==========================================================
   // state register
   // all fields leave reset on one edge
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         s_r <= CORE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // outputs, straight from the state register
   assign ahbOut = s_r.ahb;
   // no combinational path reaches a port
   assign phyOut = s_r.phy;
endmodule : pbr_phy_regs
`default_nettype wire

// ---- hw/pbr_pkg.sv ----
// package: constants, field layouts and carriers of the phy register file
package pbr_pkg;

   // ==========================================================
   // register map
   localparam int PBR_REG_COUNT = 16; // base plus paged window
   localparam int PBR_IDX_W = 4; // register index width
   localparam int PBR_IDX_LSB = 2; // word aligned: byte addr = 4 * index
   localparam int PBR_MAP_TOP = 6; // first address bit outside the map
   localparam logic [3:0] PBR_IDX_NODE = 4'h0; // node_identity
   localparam logic [3:0] PBR_IDX_RESET_GAP = 4'h1; // reset_and_gap_control
   localparam logic [3:0] PBR_IDX_PORT_CAP = 4'h2; // port_capability
   localparam logic [3:0] PBR_IDX_SPEED_CAP = 4'h3; // speed_delay_capability
   localparam logic [3:0] PBR_IDX_LINK_PWR = 4'h4; // link_power_control
   localparam logic [3:0] PBR_IDX_EVENT = 4'h5; // event_and_feature_control
   localparam logic [3:0] PBR_IDX_RSVD = 4'h6; // reserved_base
   localparam logic [3:0] PBR_IDX_PAGE = 4'h7; // page_and_port_select
   localparam int PBR_PAGED_BIT = 3; // index bit that selects paged window

   // ==========================================================
   // field layouts, bit 0 of the documented order is the msb
   typedef struct packed {
      logic [5:0] nodeAddress;
      logic root;
      logic cablePowerStatus;
   } pbr_reg_node_t;

   typedef struct packed {
      logic rootHoldoff;
      logic initiateLongReset;
      logic [5:0] gapCount;
   } pbr_reg_gap_t;

   typedef struct packed {
      logic [2:0] pageSelect;
      logic reserved;
      logic [3:0] portSelect;
   } pbr_reg_page_t;

   // ==========================================================
   // constant and reset values
   localparam logic [7:0] PBR_PORT_CAP_VAL = 8'he1; // 111b, rsvd, 0001b
   localparam logic [7:0] PBR_SPEED_CAP_VAL = 8'h40; // 010b, rsvd, 0000b
   localparam logic [5:0] PBR_GAP_RESET = 6'h3f; // gap count default
   localparam logic [2:0] PBR_PAGE_RSVD_LO = 3'h2; // first reserved page
   localparam logic [2:0] PBR_PAGE_RSVD_HI = 3'h6; // last reserved page

   // ==========================================================
   // timing
   localparam int PBR_CLK_MHZ = 25; // sys_clk rate
   localparam int PBR_LONG_RESET_US = 166; // long bus reset length
   localparam int PBR_LONG_RESET_CYCLES = PBR_LONG_RESET_US * PBR_CLK_MHZ;

   // ==========================================================
   // ahb-lite encodings
   localparam logic [2:0] PBR_HSIZE_WORD = 3'h2;
   localparam logic PBR_HRESP_OKAY = 1'h0;
   localparam int PBR_HTRANS_ACTIVE = 1; // htrans bit set for NONSEQ/SEQ

   // ==========================================================
   // carriers
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
      logic [31:0] hwdata;
   } pbr_ahb_in_t;

   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } pbr_ahb_out_t;

   typedef struct packed {
      logic busReset; // pulse: bus reset seen on the cable
      logic selfIdDone; // pulse: self-identification finished
      logic [5:0] selfIdAddress; // address found, valid with selfIdDone
      logic becameRoot; // pulse: tree identification made us root
      logic linkBusy; // level: receive or transmit in progress
      logic phyConfigRx; // pulse: PHY_CONFIG packet received
      logic phyConfigTx; // pulse: PHY_CONFIG packet sent
      logic [5:0] phyConfigGap; // gap value carried by the packet
   } pbr_phy_in_t;

   typedef struct packed {
      logic longResetActive; // level: drive long bus reset
      logic nodeAddressValid; // level: node address is valid
      logic statusXferReq; // pulse: unsolicited register 0 status
      logic [7:0] statusXferData; // register 0 image for that transfer
      logic rootHoldoff; // level: try to become root
      logic [5:0] gapCount; // arbitration gap timing value
      logic [2:0] pageSelect; // selected page
      logic [3:0] portSelect; // selected port
   } pbr_phy_out_t;

   typedef enum logic [1:0] {
      PBR_ST_IDLE = 2'h0,
      PBR_ST_WAIT = 2'h1,
      PBR_ST_DRIVE = 2'h2
   } pbr_state_t;

endpackage : pbr_pkg

// ---- hw/pbr_sync.sv ----
// module: two flip-flop synchroniser for levels entering sys_clk
`timescale 1ns/1ps
`default_nettype none
module pbr_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // level in and out
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   // ==========================================================
   // state
   typedef struct packed {
      logic [WIDTH-1:0] meta; // first stage, read only by second
      logic [WIDTH-1:0] stable; // second stage
   } pbr_sync_t;

   pbr_sync_t s_r;
   pbr_sync_t s_nxt;

   if (WIDTH < 1) begin : gBadWidth
      $error("pbr_sync: WIDTH must be at least 1");
   end

   // shift one stage per clock
   always_comb begin
      s_nxt = s_r;
      s_nxt.meta = d;
      s_nxt.stable = s_r.meta;
   end

   // register with asynchronous clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.stable;
endmodule : pbr_sync
`default_nettype wire

// ---- testbench/pbr_phy_core_model.sv ----
// model: phy core raising cable events toward the register file
`timescale 1ns/1ps
`default_nettype none
module pbr_phy_core_model (
   // clock
   input wire logic sys_clk,
   // events toward the register file
   output var pbr_pkg::pbr_phy_in_t phyIn
);
   import pbr_pkg::*;
   // quiet at time zero
   initial phyIn = '0;
   // one-cycle pulse; which = {reset, selfid, root, cfgrx, cfgtx}
   task automatic fire(input logic [4:0] which, input logic [5:0] val);
      pbr_phy_in_t e;
      e = phyIn;
      {e.busReset, e.selfIdDone, e.becameRoot, e.phyConfigRx,
         e.phyConfigTx} = which;
      e.selfIdAddress = val;
      e.phyConfigGap = val;
      phyIn <= e;
      @(posedge sys_clk);
      // value fields expire: show the inverse, never a stale copy
      {e.busReset, e.selfIdDone, e.becameRoot, e.phyConfigRx,
         e.phyConfigTx} = 5'h0;
      e.selfIdAddress = ~val;
      e.phyConfigGap = ~val;
      phyIn <= e;
   endtask : fire
   // receive or transmit traffic level
   task automatic busy(input logic b);
      @(posedge sys_clk);
      phyIn.linkBusy <= b;
   endtask : busy
endmodule : pbr_phy_core_model
`default_nettype wire

// ---- testbench/pbr_phy_regs_chk.sv ----
// checker: port assertions for the phy register file
`timescale 1ns/1ps
`default_nettype none
module pbr_phy_regs_chk #(
   parameter int LONG_RESET_CYCLES = pbr_pkg::PBR_LONG_RESET_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register bus
   input wire pbr_pkg::pbr_ahb_in_t ahbIn,
   input wire pbr_pkg::pbr_ahb_out_t ahbOut,
   // phy side
   input wire logic cablePowerStatus,
   input wire pbr_pkg::pbr_phy_in_t phyIn,
   input wire pbr_pkg::pbr_phy_out_t phyOut
);
   import pbr_pkg::*;
   // ==========================================
   // helper state
   logic wrPend_r; // a write sits in its data phase
   int runCnt_r; // cycles the long reset has been driven
   // track data phases and the long reset length
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPend_r <= 1'b0;
         runCnt_r <= 0;
      end else begin
         wrPend_r <= ahbIn.hsel && ahbIn.htrans[1] && ahbIn.hready
            && ahbIn.hwrite;
         runCnt_r <= phyOut.longResetActive ? runCnt_r + 1 : 0;
      end
   end
   // ==========================================
   // assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_bus_okay: assert property (
      ahbOut.hreadyout && ahbOut.hresp == PBR_HRESP_OKAY)
      else $error("bus not ready or not okay");
   a_upper_zero: assert property (
      ahbOut.hrdata[31:8] == 24'h0)
      else $error("read data above bit 7 not zero");
   a_status_cause: assert property (
      phyIn.selfIdDone |=> phyOut.statusXferReq
      && phyOut.statusXferData[7:2] == $past(phyIn.selfIdAddress))
      else $error("no status transfer after self-id");
   a_status_only: assert property (
      phyOut.statusXferReq |-> $past(phyIn.selfIdDone))
      else $error("status transfer without self-id");
   a_config_gap: assert property (
      (phyIn.phyConfigRx || phyIn.phyConfigTx) && !wrPend_r
      |=> phyOut.gapCount == $past(phyIn.phyConfigGap))
      else $error("config packet did not set gap");
   a_long_len: assert property (
      $fell(phyOut.longResetActive) |-> runCnt_r == LONG_RESET_CYCLES)
      else $error("long reset of wrong length");
   a_busy_hold: assert property (
      $rose(phyOut.longResetActive) |-> !$past(phyIn.linkBusy))
      else $error("long reset began during traffic");
   a_holdoff_keep: assert property (
      phyIn.busReset && !wrPend_r |=> $stable(phyOut.rootHoldoff))
      else $error("holdoff changed by bus reset");
endmodule : pbr_phy_regs_chk
`default_nettype wire

// ---- testbench/pbr_phy_regs_tb.sv ----
// testbench: phy register file against a bench model
`timescale 1ns/1ps
`default_nettype none
module pbr_phy_regs_tb;
   import pbr_pkg::*;
   localparam int LRC = 8; // shortened long reset
   localparam logic [4:0] EV_BR = 5'h10; // bus reset
   localparam logic [4:0] EV_SID = 5'h08; // self-id done
   localparam logic [4:0] EV_ROOT = 5'h04; // became root
   localparam logic [4:0] EV_CRX = 5'h02; // config received
   localparam logic [4:0] EV_CTX = 5'h01; // config sent
   // ==========================================
   // signals
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cablePowerStatus = 1'b1;
   pbr_ahb_in_t mst; // master drive
   pbr_ahb_in_t ahbIn;
   pbr_ahb_out_t ahbOut;
   pbr_phy_in_t phyIn;
   pbr_phy_out_t phyOut;
   int fails = 0;
   int checks = 0;
   // bench model of the fields
   int mGap = 63, mRhb = 0, mRoot = 0, mNode = 0;
   int mPage = 0, mPort = 0, mCps = 1, mBr = 0;
   // 25 MHz clock
   always #20 sys_clk = ~sys_clk;
   // single slave: hready loops back
   always_comb begin
      ahbIn = mst;
      ahbIn.hready = ahbOut.hreadyout;
   end
   pbr_phy_regs #(.LONG_RESET_CYCLES(LRC)) i_dut (.sys_clk(sys_clk),
      .rst_n(rst_n), .ahbIn(ahbIn), .ahbOut(ahbOut),
      .cablePowerStatus(cablePowerStatus), .phyIn(phyIn), .phyOut(phyOut));
   pbr_phy_core_model i_core (.sys_clk(sys_clk), .phyIn(phyIn));
   // ==========================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // expected register image from the model
   function automatic logic [7:0] expReg(input int i);
      case (i)
         0: return {6'(mNode), 1'(mRoot), 1'(mCps)};
         1: return {1'(mRhb), 1'b0, 6'(mGap)};
         2: return {3'h7, 1'h0, 4'h1};
         3: return {3'h2, 1'h0, 4'h0};
         7: return {3'(mPage), 1'h0, 4'(mPort)};
         default: return 8'h0;
      endcase
   endfunction : expReg
   // one single word transfer
   task automatic bus(input logic wr, input logic [31:0] a,
         input logic [7:0] d, output logic [31:0] q);
      mst.hsel <= 1'b1;
      mst.htrans <= 2'h2;
      mst.haddr <= a;
      mst.hwrite <= wr;
      mst.hsize <= PBR_HSIZE_WORD;
      do @(posedge sys_clk); while (ahbOut.hreadyout !== 1'b1);
      mst.htrans <= 2'h0;
      mst.hwdata <= {24'($urandom()), d};
      do @(posedge sys_clk); while (ahbOut.hreadyout !== 1'b1);
      q = ahbOut.hrdata;
   endtask : bus
   task automatic wrReg(input int i, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, 32'(i) << 2, d, q);
      if (i == 1) begin
         mRhb = d[7];
         mGap = d[5:0];
         mBr = 0;
      end
      if (i == 7) begin
         mPage = d[7:5];
         mPort = d[3:0];
      end
   endtask : wrReg
   task automatic rdChk(input int i);
      logic [31:0] q;
      bus(1'b0, 32'(i) << 2, 8'h0, q);
      chk(q, {24'h0, expReg(i)});
   endtask : rdChk
   // one phy event, mirrored into the model
   task automatic ev(input logic [4:0] w, input logic [5:0] v);
      @(posedge sys_clk);
      i_core.fire(w, v);
      if (w[4]) begin
         mRoot = 0;
         mBr++;
         if (mBr >= 2) mGap = 63;
      end
      if (w[3]) mNode = v;
      if (w[2]) mRoot = 1;
      if (w[1] | w[0]) begin
         mGap = v;
         mBr = 0;
      end
   endtask : ev
   task automatic give_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict
   // ==========================================
   // watchdog
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      give_verdict();
   end
   // ==========================================
   // main sequence
   initial begin
      int n;
      logic [31:0] q;
      mst = '0;
      void'($urandom(32'ha730));
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge sys_clk); // let the pin synchroniser fill
      // test 1: reset contents
      for (int i = 0; i < 16; i++) rdChk(i);
      $display("test 1 done");
      // test 2: each page, writes everywhere, read back
      for (int p = 0; p < 8; p++) begin
         wrReg(7, {3'(p), 1'b1, 4'($urandom())});
         for (int i = 0; i < 16; i++) begin
            if (i != 7) wrReg(i, 8'($urandom()) & 8'hbf);
         end
         for (int i = 0; i < 16; i++) rdChk(i);
         chk(32'(phyOut.pageSelect), 32'(mPage));
         chk(32'(phyOut.portSelect), 32'(mPort));
      end
      bus(1'b1, 32'h44, 8'hff, q);
      bus(1'b0, 32'h40, 8'h0, q);
      chk(q, 32'h0);
      rdChk(1);
      $display("test 2 done");
      // test 3: self-id, root, cable power, gap across bus resets
      wrReg(1, 8'h95);
      ev(EV_BR, 6'h0);
      ev(EV_ROOT, 6'h0);
      ev(EV_SID, 6'h2a);
      @(posedge sys_clk);
      chk(32'(phyOut.nodeAddressValid), 32'h1);
      rdChk(0);
      rdChk(1);
      chk(32'(phyOut.rootHoldoff), 32'(mRhb));
      ev(EV_BR, 6'h0);
      rdChk(1);
      chk(32'(phyOut.nodeAddressValid), 32'h0);
      ev(EV_CRX, 6'h0a);
      ev(EV_BR, 6'h0);
      ev(EV_CTX, 6'h2b);
      ev(EV_BR, 6'h0);
      rdChk(1);
      chk(32'(phyOut.gapCount), 32'(mGap));
      ev(EV_BR, 6'h0);
      rdChk(1);
      ev(EV_SID, 6'h15);
      cablePowerStatus <= 1'b0;
      mCps = 0;
      repeat (4) @(posedge sys_clk);
      rdChk(0);
      $display("test 3 done");
      // test 4: long reset waits for traffic, then runs its length
      i_core.busy(1'b1);
      wrReg(1, 8'h40 | 8'(mGap));
      repeat (6) @(posedge sys_clk);
      chk(32'(phyOut.longResetActive), 32'h0);
      i_core.busy(1'b0);
      n = 0;
      while (phyOut.longResetActive !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      n = 0;
      while (phyOut.longResetActive === 1'b1 && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      chk(32'(n), 32'(LRC));
      rdChk(1);
      // a bus reset while waiting drops the request
      i_core.busy(1'b1);
      wrReg(1, 8'h40 | 8'(mGap));
      ev(EV_BR, 6'h0);
      i_core.busy(1'b0);
      n = 0;
      repeat (20) begin
         @(posedge sys_clk);
         if (phyOut.longResetActive !== 1'b0) n++;
      end
      chk(32'(n), 32'h0);
      rdChk(1);
      $display("test 4 done");
      give_verdict();
   end
endmodule : pbr_phy_regs_tb
bind pbr_phy_regs pbr_phy_regs_chk #(
   .LONG_RESET_CYCLES(LONG_RESET_CYCLES)
) i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .ahbIn(ahbIn),
   .ahbOut(ahbOut), .cablePowerStatus(cablePowerStatus),
   .phyIn(phyIn), .phyOut(phyOut));
`default_nettype wire
